/* dsc_pkg.sv */
// shared constants for the dual converter conversion control block
`default_nettype none
package dsc_pkg;
    // register byte offsets
    localparam logic [7:0] DSC_OFS_CTRL = 8'h00;
    localparam logic [7:0] DSC_OFS_STATUS = 8'h04;
    localparam logic [7:0] DSC_OFS_RESULT_A = 8'h08;
    localparam logic [7:0] DSC_OFS_RESULT_B = 8'h0C;
    localparam logic [7:0] DSC_OFS_COUNT = 8'h10;
    // control register fields
    localparam int DSC_CTRL_LOW_RES_BIT = 0;
    localparam logic DSC_CTRL_LOW_RES_RST = 1'b0;
    // status register fields
    localparam int DSC_ST_BUSY_BIT = 0;
    localparam int DSC_ST_PDOWN_BIT = 1;
    localparam int DSC_ST_CHAN_APPLIED_BIT = 2;
    localparam int DSC_ST_CHAN_NEXT_BIT = 3;
    localparam int DSC_ST_SPAN_LO_BIT = 4;
    localparam int DSC_ST_SPAN_HI_BIT = 5;
    localparam int DSC_ST_REF_INT_BIT = 6;
    localparam int DSC_ST_BAD_SPAN_BIT = 7;
    // input span codes
    localparam logic [1:0] DSC_SPAN_PM10 = 2'h0;
    localparam logic [1:0] DSC_SPAN_PM5 = 2'h1;
    localparam logic [1:0] DSC_SPAN_UNI10 = 2'h2;
    localparam logic [1:0] DSC_SPAN_BAD = 2'h3;
    // reset values
    localparam logic DSC_CHAN_RST = 1'b0;
    localparam logic [1:0] DSC_SPAN_RST = 2'h0;
    // resolutions: full width and the low-resolution variant
    localparam int DSC_RES_HI = 14;
    localparam int DSC_RES_LO = 12;
    // internal oscillator: hclk cycles per successive-approximation step
    localparam int DSC_OSC_DIV = 2;
    // hclk edges after reset release before the reference strap is caught
    localparam logic [1:0] DSC_STRAP_WAIT = 2'h2;
    // ahb
    localparam logic [1:0] DSC_HTRANS_NONSEQ = 2'h2;
    localparam logic DSC_HRESP_OKAY = 1'b0;
    typedef enum logic [1:0] {
        DSC_ST_IDLE = 2'b01,
        DSC_ST_CONV = 2'b10
    } dsc_state_t;
endpackage
`default_nettype wire

/* dsc_conv_ctrl.sv */
// conversion control for a dual simultaneous-sampling successive-approximation converter
// What this block does
// - start falling edge holds both samplers and starts both conversions together.
// - busy is high during conversion, low once both results are done.
// - samplers return to tracking when busy falls.
// - approximation steps run from an internal oscillator, not the serial clock.
// - after conversion the host reads results shifted out on its serial clock.
// - two separate serial data outputs, one per converter.
// - span select 00 +/-10 V, 01 +/-5 V, 10 0-10 V; 11 is applied as is and flagged in status.
// - channel select latched on busy rising, applied to the following conversion.
// - latched channel 0 routes first inputs, 1 routes second inputs.
// - after reset the first input of each converter is selected.
// - results are delivered in two's complement.
// - codes step at whole LSBs; span over 4096 or 16384.
// - each converter has two single-ended inputs chosen by channel select.
// - 12-bit or 14-bit result, one word per converter per conversion.
// - start still low at conversion end powers down; its rising edge wakes.
`default_nettype none
module dsc_conv_ctrl #(
    parameter int RES_W = dsc_pkg::DSC_RES_HI,
    parameter int OSC_DIV = dsc_pkg::DSC_OSC_DIV
) (
    // system clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // conversion control pins
    input wire logic conversion_start_n,
    input wire logic channel_pair_sel,
    input wire logic input_span_sel_lo,
    input wire logic input_span_sel_hi,
    input wire logic reference_source_select,
    output logic busy,
    output logic track_hold_hold,
    output logic mux_second_sel,
    output logic [1:0] span_applied,
    output logic reference_internal,
    output logic powered_down,
    // sampled analog levels, offset binary, 0 = bottom of span
    input wire logic [RES_W-1:0] conv_a_input_first,
    input wire logic [RES_W-1:0] conv_a_input_second,
    input wire logic [RES_W-1:0] conv_b_input_first,
    input wire logic [RES_W-1:0] conv_b_input_second,
    // serial read link
    input wire logic link_sclk,
    output logic dout_a,
    output logic dout_b
);
    localparam int BIT_W = $clog2(RES_W);
    localparam int DIV_W = $clog2(OSC_DIV + 1);
    localparam logic [BIT_W-1:0] MSB_IDX = BIT_W'(RES_W - 1);
    localparam logic [BIT_W-1:0] LSB_LO = BIT_W'(RES_W - dsc_pkg::DSC_RES_LO);

    // pin synchronisers: s1 is read only by s2
    logic start_s1_q, start_s2_q, start_s3_q;
    logic chan_s1_q, chan_s2_q;
    logic [1:0] span_s1_q, span_s2_q;
    logic ref_s1_q, ref_s2_q;
    logic [RES_W-1:0] a1_s1_q, a2_s1_q, b1_s1_q, b2_s1_q;
    logic [RES_W-1:0] a1_s2_q, a2_s2_q, b1_s2_q, b2_s2_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_s1_q <= 1'b1;
            start_s2_q <= 1'b1;
            start_s3_q <= 1'b1;
            chan_s1_q <= 1'b0;
            chan_s2_q <= 1'b0;
            span_s1_q <= 2'h0;
            span_s2_q <= 2'h0;
            ref_s1_q <= 1'b0;
            ref_s2_q <= 1'b0;
            a1_s1_q <= '0;
            a2_s1_q <= '0;
            b1_s1_q <= '0;
            b2_s1_q <= '0;
            a1_s2_q <= '0;
            a2_s2_q <= '0;
            b1_s2_q <= '0;
            b2_s2_q <= '0;
        end else begin
            start_s1_q <= conversion_start_n;
            start_s2_q <= start_s1_q;
            start_s3_q <= start_s2_q;
            chan_s1_q <= channel_pair_sel;
            chan_s2_q <= chan_s1_q;
            span_s1_q <= {input_span_sel_hi, input_span_sel_lo};
            span_s2_q <= span_s1_q;
            ref_s1_q <= reference_source_select;
            ref_s2_q <= ref_s1_q;
            a1_s1_q <= conv_a_input_first;
            a2_s1_q <= conv_a_input_second;
            b1_s1_q <= conv_b_input_first;
            b2_s1_q <= conv_b_input_second;
            a1_s2_q <= a1_s1_q;
            a2_s2_q <= a2_s1_q;
            b1_s2_q <= b1_s1_q;
            b2_s2_q <= b2_s1_q;
        end
    end

    logic start_fall, start_rise;
    assign start_fall = start_s3_q && !start_s2_q;
    assign start_rise = !start_s3_q && start_s2_q;

    // reference strap caught after release, never under reset
    logic [1:0] strap_cnt_q;
    logic ref_internal_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_cnt_q <= 2'h0;
            ref_internal_q <= 1'b0;
        end else if (strap_cnt_q != 2'h3) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == dsc_pkg::DSC_STRAP_WAIT) begin
                ref_internal_q <= ref_s2_q;
            end
        end
    end

    // conversion sequencer
    dsc_pkg::dsc_state_t state_q;
    logic busy_q, hold_q, pdown_q, low_res_q;
    logic chan_next_q, chan_applied_q;
    logic [1:0] span_q;
    logic [DIV_W-1:0] osc_q;
    logic [BIT_W-1:0] bit_q;
    logic [RES_W-1:0] sample_a_q, sample_b_q, code_a_q, code_b_q;
    logic [RES_W-1:0] result_a_q, result_b_q, code_a_d, code_b_d, trial_a, trial_b;
    logic [31:0] count_q;
    logic res_tog_q;
    logic osc_tick, last_step, conv_done, accept_start;

    function automatic logic [RES_W-1:0] bit_mask(input logic [BIT_W-1:0] idx);
        bit_mask = RES_W'(1) << idx;
    endfunction

    // internal oscillator step, independent of the serial clock
    assign osc_tick = (state_q == dsc_pkg::DSC_ST_CONV) && (osc_q == DIV_W'(OSC_DIV - 1));
    assign last_step = bit_q == (low_res_q ? LSB_LO : '0);
    assign conv_done = osc_tick && last_step;
    // a start edge while busy or asleep is dropped
    assign accept_start = (state_q == dsc_pkg::DSC_ST_IDLE) && start_fall && !pdown_q;
    // one comparison per step: keep the trial bit when the held level reaches it
    assign trial_a = code_a_q | bit_mask(bit_q);
    assign trial_b = code_b_q | bit_mask(bit_q);
    assign code_a_d = (sample_a_q >= trial_a) ? trial_a : code_a_q;
    assign code_b_d = (sample_b_q >= trial_b) ? trial_b : code_b_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= dsc_pkg::DSC_ST_IDLE;
            busy_q <= 1'b0;
            hold_q <= 1'b0;
            osc_q <= '0;
            bit_q <= MSB_IDX;
            sample_a_q <= '0;
            sample_b_q <= '0;
            code_a_q <= '0;
            code_b_q <= '0;
        end else begin
            unique case (state_q)
                dsc_pkg::DSC_ST_IDLE: begin
                    if (accept_start) begin
                        state_q <= dsc_pkg::DSC_ST_CONV;
                        busy_q <= 1'b1;
                        hold_q <= 1'b1;
                        osc_q <= '0;
                        bit_q <= MSB_IDX;
                        code_a_q <= '0;
                        code_b_q <= '0;
                        // both held at the same edge, pair chosen by the latched select
                        sample_a_q <= chan_next_q ? a2_s2_q : a1_s2_q;
                        sample_b_q <= chan_next_q ? b2_s2_q : b1_s2_q;
                    end
                end
                dsc_pkg::DSC_ST_CONV: begin
                    osc_q <= osc_tick ? '0 : osc_q + DIV_W'(1);
                    if (osc_tick) begin
                        code_a_q <= code_a_d;
                        code_b_q <= code_b_d;
                        bit_q <= bit_q - BIT_W'(1);
                    end
                    if (conv_done) begin
                        state_q <= dsc_pkg::DSC_ST_IDLE;
                        busy_q <= 1'b0;
                        hold_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    // results: offset binary turned to two's complement by inverting the top bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_a_q <= '0;
            result_b_q <= '0;
            res_tog_q <= 1'b0;
            count_q <= '0;
        end else if (conv_done) begin
            result_a_q <= code_a_d ^ bit_mask(MSB_IDX);
            result_b_q <= code_b_d ^ bit_mask(MSB_IDX);
            res_tog_q <= ~res_tog_q;
            count_q <= count_q + 32'h1;
        end
    end

    // channel pair: taken on busy rising, used by the conversion after this one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chan_next_q <= dsc_pkg::DSC_CHAN_RST;
            chan_applied_q <= dsc_pkg::DSC_CHAN_RST;
            span_q <= dsc_pkg::DSC_SPAN_RST;
        end else if (accept_start) begin
            chan_applied_q <= chan_next_q;
            chan_next_q <= chan_s2_q;
            span_q <= span_s2_q;
        end
    end

    // power-down when start is still low at the end; its rising edge wakes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pdown_q <= 1'b0;
        end else if (conv_done && !start_s2_q) begin
            pdown_q <= 1'b1;
        end else if (start_rise) begin
            pdown_q <= 1'b0;
        end
    end

    // ahb-lite slave, zero wait states, data read out in the data phase
    logic addr_ok, wr_pend_q, bad_span_q;
    logic [7:0] wr_ofs_q;
    logic [31:0] rd_d;
    assign addr_ok = hsel && hready && htrans == dsc_pkg::DSC_HTRANS_NONSEQ;

    function automatic logic [31:0] sext_result(input logic [RES_W-1:0] r, input logic lo);
        sext_result = lo ? 32'($signed(r[RES_W-1:RES_W-dsc_pkg::DSC_RES_LO]))
                         : 32'($signed(r));
    endfunction

    always_comb begin
        rd_d = 32'h0;
        unique case (haddr[7:0])
            dsc_pkg::DSC_OFS_CTRL: rd_d[dsc_pkg::DSC_CTRL_LOW_RES_BIT] = low_res_q;
            dsc_pkg::DSC_OFS_STATUS: begin
                rd_d[dsc_pkg::DSC_ST_BUSY_BIT] = busy_q;
                rd_d[dsc_pkg::DSC_ST_PDOWN_BIT] = pdown_q;
                rd_d[dsc_pkg::DSC_ST_CHAN_APPLIED_BIT] = chan_applied_q;
                rd_d[dsc_pkg::DSC_ST_CHAN_NEXT_BIT] = chan_next_q;
                rd_d[dsc_pkg::DSC_ST_SPAN_LO_BIT] = span_q[0];
                rd_d[dsc_pkg::DSC_ST_SPAN_HI_BIT] = span_q[1];
                rd_d[dsc_pkg::DSC_ST_REF_INT_BIT] = ref_internal_q;
                rd_d[dsc_pkg::DSC_ST_BAD_SPAN_BIT] = bad_span_q;
            end
            dsc_pkg::DSC_OFS_RESULT_A: rd_d = sext_result(result_a_q, low_res_q);
            dsc_pkg::DSC_OFS_RESULT_B: rd_d = sext_result(result_b_q, low_res_q);
            dsc_pkg::DSC_OFS_COUNT: rd_d = count_q;
            default: rd_d = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= dsc_pkg::DSC_HRESP_OKAY;
            wr_pend_q <= 1'b0;
            wr_ofs_q <= 8'h0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= dsc_pkg::DSC_HRESP_OKAY;
            wr_pend_q <= addr_ok && hwrite;
            wr_ofs_q <= haddr[7:0];
            hrdata <= (addr_ok && !hwrite) ? rd_d : 32'h0;
        end
    end

    // software writes: resolution select steers the sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_res_q <= dsc_pkg::DSC_CTRL_LOW_RES_RST;
        end else if (wr_pend_q && wr_ofs_q == dsc_pkg::DSC_OFS_CTRL && state_q == dsc_pkg::DSC_ST_IDLE) begin
            // ignored mid-conversion so a half-done result keeps one width
            low_res_q <= hwdata[dsc_pkg::DSC_CTRL_LOW_RES_BIT];
        end
    end

    // forbidden span code flag: a new event beats a same-cycle clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bad_span_q <= 1'b0;
        end else if (accept_start && span_s2_q == dsc_pkg::DSC_SPAN_BAD) begin
            bad_span_q <= 1'b1;
        end else if (wr_pend_q && wr_ofs_q == dsc_pkg::DSC_OFS_STATUS && hwdata[dsc_pkg::DSC_ST_BAD_SPAN_BIT]) begin
            bad_span_q <= 1'b0;
        end
    end

    assign busy = busy_q;
    assign track_hold_hold = hold_q;
    assign mux_second_sel = chan_next_q;
    assign span_applied = span_q;
    assign reference_internal = ref_internal_q;
    assign powered_down = pdown_q;

    // serial link domain: words cross by a toggle, they stay put until the next conversion ends
    logic tog_s1_q, tog_s2_q, tog_seen_q;
    logic [RES_W-1:0] shift_a_q, shift_b_q;
    always_ff @(posedge link_sclk or negedge hresetn) begin
        if (!hresetn) begin
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_seen_q <= 1'b0;
            shift_a_q <= '0;
            shift_b_q <= '0;
        end else begin
            tog_s1_q <= res_tog_q;
            tog_s2_q <= tog_s1_q;
            tog_seen_q <= tog_s2_q;
            if (tog_s2_q != tog_seen_q) begin
                shift_a_q <= result_a_q;
                shift_b_q <= result_b_q;
            end else begin
                shift_a_q <= {shift_a_q[RES_W-2:0], 1'b0};
                shift_b_q <= {shift_b_q[RES_W-2:0], 1'b0};
            end
        end
    end
    assign dout_a = shift_a_q[RES_W-1];
    assign dout_b = shift_b_q[RES_W-1];

    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic [7:0] busy_len_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_len_q <= 8'h0;
        end else begin
            busy_len_q <= busy_q ? busy_len_q + 8'h1 : 8'h0;
        end
    end

    chk_start_holds: assert property (accept_start |=> busy_q && hold_q)
        else $error("start edge did not enter hold");
    chk_busy_length: assert property (busy_len_q <= 8'(RES_W * OSC_DIV))
        else $error("busy stayed high too long");
    chk_track_on_fall: assert property ($fell(busy_q) |-> $fell(hold_q))
        else $error("sampler not tracking after busy fell");
    // a restart would reload the top bit index, normal stepping never returns to it
    chk_restart_ignored: assert property (busy_q && start_fall && !conv_done |=>
        busy_q && $stable(sample_a_q) && $stable(sample_b_q) && bit_q != MSB_IDX)
        else $error("conversion restarted while busy");
    chk_chan_latch: assert property ($rose(busy_q) |-> chan_next_q == $past(chan_s2_q))
        else $error("channel select not latched at busy rise");
    chk_chan_apply: assert property ($rose(busy_q) |-> chan_applied_q == $past(chan_next_q))
        else $error("channel select applied to wrong conversion");
    chk_mux_route: assert property ($rose(busy_q) |->
        sample_a_q == (chan_applied_q ? $past(a2_s2_q) : $past(a1_s2_q)))
        else $error("wrong input routed to converter a");
    chk_twos_result: assert property ($fell(busy_q) && !low_res_q |->
        result_a_q == (sample_a_q ^ bit_mask(MSB_IDX)) && result_b_q == (sample_b_q ^ bit_mask(MSB_IDX)))
        else $error("result not two's complement of held level");
    chk_power_down: assert property ($fell(busy_q) && !$past(start_s2_q) |-> pdown_q)
        else $error("no power-down with start held low");
    chk_span_flag: assert property (accept_start && span_s2_q == dsc_pkg::DSC_SPAN_BAD |=> bad_span_q)
        else $error("forbidden span not flagged");

    cov_conversion: cover property ($rose(busy_q) ##[1:60] $fell(busy_q));
    cov_power_down: cover property ($rose(pdown_q) ##[1:200] $fell(pdown_q));
    cov_second_pair: cover property ($rose(busy_q) && chan_applied_q);
    cov_low_res: cover property ($fell(busy_q) && low_res_q);
endmodule
`default_nettype wire

/* dsc_host_reader.sv */
// host serial port model: clocks one frame per request and collects both result words
`default_nettype none
module dsc_host_reader (
    // frame request from the bench
    input wire logic read_req,
    output logic read_done,
    output logic [13:0] word_a,
    output logic [13:0] word_b,
    // serial link
    output logic link_sclk,
    input wire logic dout_a,
    input wire logic dout_b
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        link_sclk = 1'b0;
        read_done = 1'b0;
        word_a = 14'h0000;
        word_b = 14'h0000;
        forever begin
            @(posedge read_req);
            read_done = 1'b0;
            // odd offset keeps the link clock out of step with the system clock
            #17.3;
            // clock stands still between frames: two priming edges, then one bit per edge
            for (int i = 1; i <= 16; i++) begin
                #62.5 link_sclk = 1'b1;
                #62.5 link_sclk = 1'b0;
                // taken on the falling edge, half a period after the shift
                if (i > 2) begin
                    word_a = {word_a[12:0], dout_a};
                    word_b = {word_b[12:0], dout_b};
                end
            end
            read_done = 1'b1;
        end
    end
endmodule
`default_nettype wire

/* dsc_conv_ctrl_tb.sv */
// self-checking bench for the dual converter conversion control block
`default_nettype none
module dsc_conv_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int CONV_DIV = 2;
    typedef struct packed {
        logic sel;
        logic [1:0] span;
        logic [13:0] a1, a2, b1, b2;
    } dsc_tb_row_t;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, span_applied;
    logic [2:0] hsize;
    wire logic hready;
    logic busy, track_hold_hold, mux_second_sel, reference_internal, powered_down;
    logic conversion_start_n, channel_pair_sel, input_span_sel_lo, input_span_sel_hi, reference_source_select;
    logic [13:0] conv_a_input_first, conv_a_input_second, conv_b_input_first, conv_b_input_second;
    logic link_sclk, dout_a, dout_b, read_req, read_done, cur_sel;
    logic [13:0] word_a, word_b;
    int err_total = 0;
    int samples_checked = 0;
    int conv_cnt = 0;
    dsc_tb_row_t rows [4];

    assign hready = hreadyout;
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    dsc_conv_ctrl #(.RES_W(14), .OSC_DIV(CONV_DIV)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .conversion_start_n(conversion_start_n), .channel_pair_sel(channel_pair_sel),
        .input_span_sel_lo(input_span_sel_lo), .input_span_sel_hi(input_span_sel_hi),
        .reference_source_select(reference_source_select), .busy(busy), .track_hold_hold(track_hold_hold),
        .mux_second_sel(mux_second_sel), .span_applied(span_applied), .reference_internal(reference_internal),
        .powered_down(powered_down), .conv_a_input_first(conv_a_input_first),
        .conv_a_input_second(conv_a_input_second), .conv_b_input_first(conv_b_input_first),
        .conv_b_input_second(conv_b_input_second), .link_sclk(link_sclk), .dout_a(dout_a), .dout_b(dout_b)
    );
    dsc_host_reader host (
        .read_req(read_req), .read_done(read_done), .word_a(word_a), .word_b(word_b),
        .link_sclk(link_sclk), .dout_a(dout_a), .dout_b(dout_b)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // waits as long as the slave asks; only the watchdog ends a hung transfer
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= dsc_pkg::DSC_HTRANS_NONSEQ;
        hwrite <= w;
        do begin
            @(posedge hclk);
        end while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge hclk);
        end while (hready !== 1'b1);
        r = hrdata;
        check("bus answer", 32'(hresp), 32'(dsc_pkg::DSC_HRESP_OKAY));
    endtask

    task automatic run_conv(input int res, input logic [13:0] ca, input logic [13:0] cb, input logic stay_low);
        int n;
        logic [13:0] ea;
        logic [13:0] eb;
        ea = (res == 14) ? ca ^ 14'h2000 : {ca[13:2] ^ 12'h800, 2'h0};
        eb = (res == 14) ? cb ^ 14'h2000 : {cb[13:2] ^ 12'h800, 2'h0};
        n = 0;
        @(posedge hclk);
        conversion_start_n <= 1'b0;
        do begin
            @(posedge hclk);
            n++;
        end while (busy !== 1'b1 && n < 8);
        check("start latency", 32'(n >= 3 && n <= 5), 32'h1);
        check("hold at start", 32'(track_hold_hold), 32'h1);
        conversion_start_n <= !stay_low;
        n = 0;
        while (busy === 1'b1 && n < 40) begin
            @(posedge hclk);
            n++;
            // a second fall in mid-conversion must not restart it
            if (!stay_low && n == 4) conversion_start_n <= 1'b0;
            if (!stay_low && n == 8) conversion_start_n <= 1'b1;
        end
        check("busy width", 32'(n), 32'(res * CONV_DIV));
        check("hold at end", 32'(track_hold_hold), 32'h0);
        repeat (3) @(posedge hclk);
        check("power down", 32'(powered_down), 32'(stay_low));
        if (stay_low) begin
            conversion_start_n <= 1'b1;
            repeat (6) @(posedge hclk);
            check("wake", 32'({powered_down, busy}), 32'h0);
        end
        read_req <= 1'b1;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (read_done !== 1'b1 && n < 200);
        read_req <= 1'b0;
        check("serial a", 32'(word_a), 32'(ea));
        check("serial b", 32'(word_b), 32'(eb));
        check("no restart", 32'(busy), 32'h0);
        ahb(dsc_pkg::DSC_OFS_RESULT_A, 1'b0, 32'h0, rd);
        check("result a", rd, 32'($signed(ea)) >>> (14 - res));
        ahb(dsc_pkg::DSC_OFS_RESULT_B, 1'b0, 32'h0, rd);
        check("result b", rd, 32'($signed(eb)) >>> (14 - res));
        conv_cnt++;
        ahb(dsc_pkg::DSC_OFS_COUNT, 1'b0, 32'h0, rd);
        check("count", rd, 32'(conv_cnt));
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        err_total++;
        $display("watchdog expired");
        give_verdict();
    end

    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, htrans, read_req, channel_pair_sel, input_span_sel_lo, input_span_sel_hi} = 8'h00;
        haddr = 32'h0;
        hwdata = 32'h0;
        hsize = 3'h2;
        conversion_start_n = 1'b1;
        reference_source_select = 1'b1;
        {conv_a_input_first, conv_a_input_second, conv_b_input_first, conv_b_input_second} = 56'h0;
        rows[0] = {1'b1, 2'h0, 14'h0000, 14'h3FFF, 14'h2000, 14'h1FFF};
        rows[1] = {1'b0, 2'h1, 14'h1234, 14'h3FFF, 14'h0ABC, 14'h2001};
        rows[2] = {1'b1, 2'h2, 14'h1FFF, 14'h0001, 14'h3FFE, 14'h2AAA};
        rows[3] = {1'b0, 2'h0, 14'h0F0F, 14'h2AAA, 14'h1555, 14'h3C3C};
        cur_sel = 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        foreach (rows[i]) begin
            channel_pair_sel <= rows[i].sel;
            {input_span_sel_hi, input_span_sel_lo} <= rows[i].span;
            conv_a_input_first <= rows[i].a1;
            conv_a_input_second <= rows[i].a2;
            conv_b_input_first <= rows[i].b1;
            conv_b_input_second <= rows[i].b2;
            // acquisition time with span and inputs already steady
            repeat (4) @(posedge hclk);
            run_conv(14, cur_sel ? rows[i].a2 : rows[i].a1, cur_sel ? rows[i].b2 : rows[i].b1, 1'b0);
            check("next chan", 32'(mux_second_sel), 32'(rows[i].sel));
            check("span", 32'(span_applied), 32'(rows[i].span));
            check("ref", 32'(reference_internal), 32'h1);
            ahb(dsc_pkg::DSC_OFS_STATUS, 1'b0, 32'h0, rd);
            check("status", rd, {24'h0, 2'h1, rows[i].span, rows[i].sel, cur_sel, 2'h0});
            cur_sel = rows[i].sel;
        end
        $display("test table done");
        hresetn <= 1'b0;
        reference_source_select <= 1'b0;
        repeat (6) @(posedge hclk);
        check("reset pins", 32'({busy, track_hold_hold, mux_second_sel, span_applied, powered_down,
            reference_internal, dout_a, dout_b, hreadyout, hresp}), 32'h002);
        hresetn <= 1'b1;
        repeat (5) @(posedge hclk);
        ahb(dsc_pkg::DSC_OFS_STATUS, 1'b0, 32'h0, rd);
        check("status reset", rd, 32'h0);
        ahb(dsc_pkg::DSC_OFS_COUNT, 1'b0, 32'h0, rd);
        check("count reset", rd, 32'h0);
        ahb(8'h14, 1'b1, 32'hFFFFFFFF, rd);
        ahb(8'h14, 1'b0, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        conv_cnt = 0;
        $display("test reset done");
        // low resolution, a forbidden span and power-down in one conversion
        ahb(dsc_pkg::DSC_OFS_CTRL, 1'b1, 32'h1, rd);
        ahb(dsc_pkg::DSC_OFS_CTRL, 1'b0, 32'h0, rd);
        check("ctrl", rd, 32'h1);
        {input_span_sel_hi, input_span_sel_lo} <= dsc_pkg::DSC_SPAN_BAD;
        conv_a_input_first <= 14'h0ABC;
        conv_b_input_first <= 14'h3123;
        repeat (4) @(posedge hclk);
        run_conv(12, 14'h0ABC, 14'h3123, 1'b1);
        ahb(dsc_pkg::DSC_OFS_STATUS, 1'b0, 32'h0, rd);
        check("bad span", 32'(rd[7]), 32'h1);
        ahb(dsc_pkg::DSC_OFS_STATUS, 1'b1, 32'h80, rd);
        ahb(dsc_pkg::DSC_OFS_STATUS, 1'b0, 32'h0, rd);
        check("bad span clear", 32'(rd[7]), 32'h0);
        $display("test low resolution done");
        give_verdict();
    end
endmodule
`default_nettype wire
